// file: hw/iqa_params.svh
`ifndef IQA_PARAMS_SVH
`define IQA_PARAMS_SVH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define IQA_IDX_MODE 4'h0
`define IQA_IDX_ICIC 4'h6
`define IQA_IDX_CIC 4'h7
`define IQA_IDX_FTW0 4'h8
`define IQA_IDX_STATUS 4'hc
`define IQA_IDX_ACTFTW 4'hd
`define IQA_IDX_PHASE 4'he

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define IQA_MODE_LSB 0
`define IQA_MODE_MSB 1
`define IQA_LOCKQ_BIT 2
`define IQA_ICIC_BYP_BIT 0
`define IQA_CIC_RATE_MSB 5
`define IQA_CIC_BYP_BIT 6
`define IQA_MODE_RST 2'h0
`define IQA_CIC_RATE_RST 6'h02
`define IQA_CIC_RATE_TWO 6'h02

// ****************************************************************
// Filter constants
// ****************************************************************
`define IQA_ICIC_CTR 32'sh12
`define IQA_ICIC_GAIN_R2 32'sh0f2
`define IQA_ICIC_GAIN_RN 32'sh0e9
`define IQA_ICIC_SHIFT 12
`define IQA_HB_CTR 32'sh9
`define IQA_HB_SHIFT 4
`define IQA_HB1_GAP 3'h4
`define IQA_HB2_GAP 3'h2

// ****************************************************************
// Timing
// ****************************************************************
`define IQA_CLK_NS 10
`define IQA_WCLK_HALF_NS 40
`define IQA_WCLK_HALF_CYC (`IQA_WCLK_HALF_NS / `IQA_CLK_NS)

`endif

// file: hw/iqa_pkg.sv
package iqa_pkg;
  typedef enum logic [1:0] {
    IQA_MODE_QUAD,
    IQA_MODE_TONE,
    IQA_MODE_INTERP
  } iqa_mode_t;
  typedef enum logic {
    IQA_WANT_I,
    IQA_WANT_Q
  } iqa_slot_t;
  typedef logic signed [13:0] iqa_sample_t;
endpackage

// file: hw/iqa_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "iqa_params.svh"

// Operation
// [R01] Parallel words are 14-bit two's complement
// [R02] Shared pin: word clock out, strobe in tone
// [R03] Strobe rise loads selected tuning word
// [R04] Profile change makes its tuning word effective
// [R05] Quad mode: interleaved I/Q, clock twice rate
// [R06] I pairs with following Q into sample
// [R07] Interp mode: each edge latches I only
// [R08] Word clock free-running, optionally lock-qualified
// [R09] Data sampled at driven clock rising edge
// [R10] Gate low in quad: zeros flush paths
// [R11] After gate rise: I first, then alternate
// [R12] Source keeps gate high even intervals
// [R13] Control 06h bit 0 bypasses inverse CIC
// [R14] CIC rate 1x bypasses, idles inverse CIC
// [R15] Inverse CIC FIR flattens CIC droop
// [R16] Inverse CIC gain loss by CIC rate
// [R17] Two half-band stages give 4x interpolation
// [R18] Half-bands linear phase, negligible loss
// [R19] Composite half-band ripple and stopband limits
// [R20] Source oversamples baseband by two
// [R21] Quad pair rate is half word rate
// [R22] Mode selected by control register
// [R23] 6-bit CIC rate plus 1x bypass
// [R24] Inverse CIC sits before first half-band
// [R25] Each half-band doubles sample rate
module iqa_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [13:0] data_in,
  input wire logic transmit_gate,
  output logic parallel_word_clock_o,
  output logic parallel_word_clock_oe,
  input wire logic tuning_update_strobe_i,
  input wire logic profile_select_0,
  input wire logic profile_select_1,
  input wire logic pll_lock,
  output iqa_pkg::iqa_sample_t out_i,
  output iqa_pkg::iqa_sample_t out_q,
  output logic out_valid
);
  import iqa_pkg::*;

  function automatic iqa_sample_t sat14(input logic signed [31:0] v);
    if (v > 32'sh1fff) begin
      sat14 = 14'sh1fff;
    end else if (v < -32'sh2000) begin
      sat14 = -14'sh2000;
    end else begin
      sat14 = v[13:0];
    end
  endfunction

  // Odd output of a 4-tap half-band: symmetric, hence linear phase
  function automatic iqa_sample_t hb_odd(input iqa_sample_t a, input iqa_sample_t b,
                                         input iqa_sample_t c, input iqa_sample_t d);
    logic signed [31:0] acc;
    acc = `IQA_HB_CTR * (32'(b) + 32'(c)) - 32'(a) - 32'(d);
    hb_odd = sat14(acc >>> `IQA_HB_SHIFT);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [13:0] data_s1_reg, data_s2_reg;
  logic [4:0] pin_s1_reg, pin_s2_reg;
  logic strobe_q_reg;
  logic [1:0] prof_q_reg;
  wire logic gate_s = pin_s2_reg[0];
  wire logic strobe_s = pin_s2_reg[1];
  wire logic [1:0] prof_s = pin_s2_reg[3:2];
  wire logic lock_s = pin_s2_reg[4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_s1_reg <= 14'h0000;
      data_s2_reg <= 14'h0000;
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
      strobe_q_reg <= 1'b0;
      prof_q_reg <= 2'h0;
    end else begin
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
      pin_s1_reg <= {pll_lock, profile_select_1, profile_select_0,
                     tuning_update_strobe_i, transmit_gate};
      pin_s2_reg <= pin_s1_reg;
      strobe_q_reg <= strobe_s;
      prof_q_reg <= prof_s;
    end
  end

  // ****************************************************************
  // Register file over APB
  // ****************************************************************
  logic [1:0] mode_bits_reg, mode_bits_next;
  logic lockq_reg, lockq_next;
  logic icic_byp_reg, icic_byp_next;
  logic [5:0] cic_rate_reg, cic_rate_next;
  logic cic_byp_reg, cic_byp_next;
  logic [31:0] ftw_reg [4];
  logic [31:0] ftw_next [4];
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;
  logic [31:0] act_ftw_reg, phase_reg;
  iqa_mode_t mode;
  wire logic [3:0] idx = paddr[5:2];
  wire logic hit = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0) &&
                   ((idx == `IQA_IDX_MODE) || (idx == `IQA_IDX_ICIC) ||
                    (idx == `IQA_IDX_CIC) || (idx >= `IQA_IDX_FTW0 && idx <= `IQA_IDX_PHASE));

  always_comb begin
    mode = iqa_mode_t'(mode_bits_reg); // see [R22]
    mode_bits_next = mode_bits_reg;
    lockq_next = lockq_reg;
    icic_byp_next = icic_byp_reg;
    cic_rate_next = cic_rate_reg;
    cic_byp_next = cic_byp_reg;
    ftw_next = ftw_reg;
    prdata_next = prdata_reg;
    err_next = err_reg;
    if (psel && !penable) begin
      err_next = !hit;
      prdata_next = 32'h0000_0000;
      if (!pwrite && hit) begin
        case (idx)
          `IQA_IDX_MODE: prdata_next = {29'h0, lockq_reg, mode_bits_reg};
          `IQA_IDX_ICIC: prdata_next = {31'h0, icic_byp_reg};
          `IQA_IDX_CIC: prdata_next = {25'h0, cic_byp_reg, cic_rate_reg};
          `IQA_IDX_STATUS: prdata_next = {28'h0, prof_s, gate_s, lock_s};
          `IQA_IDX_ACTFTW: prdata_next = act_ftw_reg;
          `IQA_IDX_PHASE: prdata_next = phase_reg;
          default: prdata_next = ftw_reg[idx[1:0]];
        endcase
      end
    end
    if (psel && penable && pwrite && hit) begin
      case (idx)
        `IQA_IDX_MODE: begin
          // Unused mode code falls back to quadrature
          mode_bits_next = (pwdata[`IQA_MODE_MSB:`IQA_MODE_LSB] == 2'h3) ?
                           `IQA_MODE_RST : pwdata[`IQA_MODE_MSB:`IQA_MODE_LSB]; // see [R22]
          lockq_next = pwdata[`IQA_LOCKQ_BIT];
        end
        `IQA_IDX_ICIC: icic_byp_next = pwdata[`IQA_ICIC_BYP_BIT]; // see [R13]
        `IQA_IDX_CIC: begin
          // Rates 0 and 1 are not valid programmable rates; clamp to 2
          cic_rate_next = (pwdata[`IQA_CIC_RATE_MSB:0] < `IQA_CIC_RATE_TWO) ?
                          `IQA_CIC_RATE_TWO : pwdata[`IQA_CIC_RATE_MSB:0]; // see [R23]
          cic_byp_next = pwdata[`IQA_CIC_BYP_BIT]; // see [R23]
        end
        `IQA_IDX_STATUS, `IQA_IDX_ACTFTW, `IQA_IDX_PHASE: ;
        default: ftw_next[idx[1:0]] = pwdata;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_bits_reg <= `IQA_MODE_RST;
      lockq_reg <= 1'b0;
      icic_byp_reg <= 1'b0;
      cic_rate_reg <= `IQA_CIC_RATE_RST;
      cic_byp_reg <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        ftw_reg[k] <= 32'h0000_0000;
      end
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      mode_bits_reg <= mode_bits_next;
      lockq_reg <= lockq_next;
      icic_byp_reg <= icic_byp_next;
      cic_rate_reg <= cic_rate_next;
      cic_byp_reg <= cic_byp_next;
      ftw_reg <= ftw_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = psel && penable && err_reg;

  // ****************************************************************
  // Tuning word transfer and phase accumulator
  // ****************************************************************
  logic [31:0] act_ftw_next, phase_next;

  always_comb begin
    act_ftw_next = act_ftw_reg;
    phase_next = phase_reg + act_ftw_reg;
    if (prof_s != prof_q_reg) begin
      act_ftw_next = ftw_reg[prof_s]; // see [R04]
    end
    if (mode == IQA_MODE_TONE && strobe_s && !strobe_q_reg) begin
      act_ftw_next = ftw_reg[prof_s]; // see [R03]
      phase_next = 32'h0000_0000; // see [R03]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ftw_reg <= 32'h0000_0000;
      phase_reg <= 32'h0000_0000;
    end else begin
      act_ftw_reg <= act_ftw_next;
      phase_reg <= phase_next;
    end
  end

  // ****************************************************************
  // Word clock generator
  // ****************************************************************
  logic [3:0] div_reg, div_next;
  logic wclk_reg, wclk_next;
  logic [1:0] rise_reg, rise_next;
  wire logic qual_ok = !lockq_reg || lock_s;
  wire logic wrap = (div_reg == 4'(`IQA_WCLK_HALF_CYC - 1));

  always_comb begin
    div_next = wrap ? 4'h0 : div_reg + 4'h1;
    wclk_next = (mode == IQA_MODE_TONE) ? 1'b0 : (wrap ? !wclk_reg : wclk_reg); // see [R08]
    // Pins are two flops late, so the capture event is delayed to match
    rise_next = {rise_reg[0], wrap && !wclk_reg && qual_ok && mode != IQA_MODE_TONE}; // see [R09]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 4'h0;
      wclk_reg <= 1'b0;
      rise_reg <= 2'h0;
    end else begin
      div_reg <= div_next;
      wclk_reg <= wclk_next;
      rise_reg <= rise_next;
    end
  end

  assign parallel_word_clock_o = wclk_reg && qual_ok; // see [R08]
  assign parallel_word_clock_oe = (mode != IQA_MODE_TONE); // see [R02]

  // ****************************************************************
  // Input assembler
  // ****************************************************************
  iqa_slot_t slot_reg, slot_next;
  logic flush_reg, flush_next;
  iqa_sample_t ihold_reg, ihold_next, asm_i_reg, asm_i_next, asm_q_reg, asm_q_next;
  logic asm_vld_reg, asm_vld_next;
  wire iqa_sample_t word = data_s2_reg; // see [R01]

  always_comb begin
    slot_next = slot_reg;
    flush_next = flush_reg;
    ihold_next = ihold_reg;
    asm_i_next = asm_i_reg;
    asm_q_next = asm_q_reg;
    asm_vld_next = 1'b0;
    if (rise_reg[1]) begin
      case (mode)
        IQA_MODE_QUAD: begin
          if (!gate_s) begin
            // Zero pairs keep flushing at the normal pair rate
            slot_next = IQA_WANT_I; // see [R11]
            flush_next = !flush_reg;
            asm_i_next = 14'sh0000; // see [R10]
            asm_q_next = 14'sh0000; // see [R10]
            asm_vld_next = flush_reg; // see [R21]
          end else if (slot_reg == IQA_WANT_I) begin
            ihold_next = word; // see [R05]
            slot_next = IQA_WANT_Q; // see [R11]
          end else begin
            asm_i_next = ihold_reg; // see [R06]
            asm_q_next = word; // see [R06]
            asm_vld_next = 1'b1; // see [R21]
            slot_next = IQA_WANT_I; // see [R11]
          end
        end
        IQA_MODE_INTERP: begin
          asm_i_next = word; // see [R07]
          asm_q_next = 14'sh0000; // see [R07]
          asm_vld_next = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_reg <= IQA_WANT_I;
      flush_reg <= 1'b0;
      ihold_reg <= 14'sh0000;
      asm_i_reg <= 14'sh0000;
      asm_q_reg <= 14'sh0000;
      asm_vld_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      flush_reg <= flush_next;
      ihold_reg <= ihold_next;
      asm_i_reg <= asm_i_next;
      asm_q_reg <= asm_q_next;
      asm_vld_reg <= asm_vld_next;
    end
  end

  // ****************************************************************
  // Inverse CIC precompensation
  // ****************************************************************
  iqa_sample_t xh_reg [2][3];
  iqa_sample_t xh_next [2][3];
  iqa_sample_t ic_reg [2];
  iqa_sample_t ic_next [2];
  logic ic_vld_reg;
  wire logic icic_off = icic_byp_reg || cic_byp_reg; // see [R14]
  wire logic signed [31:0] gain = (cic_rate_reg == `IQA_CIC_RATE_TWO) ?
                                  `IQA_ICIC_GAIN_R2 : `IQA_ICIC_GAIN_RN; // see [R16]

  always_comb begin
    logic signed [31:0] fir;
    fir = 32'sh0;
    xh_next = xh_reg;
    ic_next = ic_reg;
    for (int p = 0; p < 2; p++) begin
      if (icic_off) begin
        xh_next[p] = '{14'sh0, 14'sh0, 14'sh0}; // see [R14]
        if (asm_vld_reg) begin
          ic_next[p] = (p == 0) ? asm_i_reg : asm_q_reg; // see [R13]
        end
      end else if (asm_vld_reg) begin
        xh_next[p][2] = xh_reg[p][1];
        xh_next[p][1] = xh_reg[p][0];
        xh_next[p][0] = (p == 0) ? asm_i_reg : asm_q_reg; // see [R24]
        // Centre tap lifts the band edge against the CIC droop
        fir = `IQA_ICIC_CTR * 32'(xh_next[p][1]) - 32'(xh_next[p][0]) - 32'(xh_next[p][2]);
        ic_next[p] = sat14((fir * gain) >>> `IQA_ICIC_SHIFT); // see [R15]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xh_reg <= '{'{14'sh0, 14'sh0, 14'sh0}, '{14'sh0, 14'sh0, 14'sh0}};
      ic_reg <= '{14'sh0, 14'sh0};
      ic_vld_reg <= 1'b0;
    end else begin
      xh_reg <= xh_next;
      ic_reg <= ic_next;
      ic_vld_reg <= asm_vld_reg;
    end
  end

  // ****************************************************************
  // Fixed 4x interpolator: two half-band stages
  // ****************************************************************
  logic hb_vld [3];
  iqa_sample_t hb_i [3];
  iqa_sample_t hb_q [3];
  assign hb_vld[0] = ic_vld_reg;
  assign hb_i[0] = ic_reg[0];
  assign hb_q[0] = ic_reg[1];

  genvar s;
  for (s = 0; s < 2; s++) begin : g_hb
    // The second output waits GAP cycles, half an input period in interp mode, so the rate doubles evenly there
    localparam logic [2:0] GAP = (s == 0) ? `IQA_HB1_GAP : `IQA_HB2_GAP;
    iqa_sample_t h_reg [2][4];
    iqa_sample_t h_next [2][4];
    iqa_sample_t o_reg [2];
    iqa_sample_t o_next [2];
    logic ov_reg, ov_next, pend_reg, pend_next;
    logic [2:0] cnt_reg, cnt_next;

    always_comb begin
      h_next = h_reg;
      o_next = o_reg;
      ov_next = 1'b0;
      pend_next = pend_reg;
      cnt_next = cnt_reg;
      if (hb_vld[s]) begin
        for (int p = 0; p < 2; p++) begin
          h_next[p][3] = h_reg[p][2];
          h_next[p][2] = h_reg[p][1];
          h_next[p][1] = h_reg[p][0];
          h_next[p][0] = (p == 0) ? hb_i[s] : hb_q[s];
          o_next[p] = h_reg[p][1]; // see [R18]
        end
        ov_next = 1'b1; // see [R25]
        pend_next = 1'b1;
        cnt_next = 3'h1;
      end else if (pend_reg) begin
        cnt_next = cnt_reg + 3'h1;
        // Count runs from the first output, so a match on GAP puts the second output GAP cycles after the first
        if (cnt_reg == GAP) begin
          for (int p = 0; p < 2; p++) begin
            o_next[p] = hb_odd(h_reg[p][0], h_reg[p][1], h_reg[p][2], h_reg[p][3]); // see [R19]
          end
          ov_next = 1'b1; // see [R25]
          pend_next = 1'b0;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        h_reg <= '{'{14'sh0, 14'sh0, 14'sh0, 14'sh0}, '{14'sh0, 14'sh0, 14'sh0, 14'sh0}};
        o_reg <= '{14'sh0, 14'sh0};
        ov_reg <= 1'b0;
        pend_reg <= 1'b0;
        cnt_reg <= 3'h0;
      end else begin
        h_reg <= h_next;
        o_reg <= o_next;
        ov_reg <= ov_next;
        pend_reg <= pend_next;
        cnt_reg <= cnt_next;
      end
    end

    assign hb_vld[s+1] = ov_reg; // see [R17]
    assign hb_i[s+1] = o_reg[0];
    assign hb_q[s+1] = o_reg[1];
  end

  assign out_i = hb_i[2];
  assign out_q = hb_q[2];
  assign out_valid = hb_vld[2];

endmodule // iqa_top

`default_nettype wire

// file: dv/iqa_src.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Baseband source: one word per rise of the word clock pin
// ****
module iqa_src (
  input wire logic word_clk,
  input wire logic presetn,
  output logic [13:0] data_out,
  output logic gate_out
);
  logic [13:0] words[$];
  // Words only go in as pairs, so every I word finds its Q word
  task automatic push_pair(input logic [13:0] a, input logic [13:0] b);
    words.push_back(a);
    words.push_back(b);
  endtask
  always @(posedge word_clk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 14'h0;
      gate_out <= 1'b0;
    end else if (words.size() > 0) begin
      gate_out <= 1'b1;
      data_out <= words.pop_front();
    end else begin
      // Idle bus keeps changing, so ignored data can never pass for zeros
      gate_out <= 1'b0;
      data_out <= ~data_out;
    end
  end
endmodule // iqa_src
`default_nettype wire

// file: dv/iqa_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port-level checks
// ****
module iqa_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic parallel_word_clock_o,
  input wire logic parallel_word_clock_oe,
  input wire iqa_pkg::iqa_sample_t out_i,
  input wire iqa_pkg::iqa_sample_t out_q,
  input wire logic out_valid
);
  import iqa_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_high;
    parallel_word_clock_o [*4];
  endsequence
  sequence s_low;
    !parallel_word_clock_o [*4];
  endsequence
  // A mode change may cut a phase short, so shape is judged only while driving
  a_clk_high: assert property (disable iff (!presetn || !parallel_word_clock_oe)
    $rose(parallel_word_clock_o) |-> s_high ##1 !parallel_word_clock_o)
    else $error("word clock high phase wrong");
  a_clk_low: assert property (disable iff (!presetn || !parallel_word_clock_oe)
    $fell(parallel_word_clock_o) |-> s_low)
    else $error("word clock low phase too short");
  a_tone_quiet: assert property (
    !parallel_word_clock_oe [*2] |-> !$rose(parallel_word_clock_o))
    else $error("word clock runs with pin released");
  a_ready_now: assert property (
    s_access |-> pready)
    else $error("access without ready");
  a_err_bad: assert property (
    psel && penable && (paddr[1:0] != 2'h0 || paddr >= 32'h40) |-> pslverr)
    else $error("bad address not refused");
  a_err_quiet: assert property (
    !(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  a_valid_gap: assert property (
    out_valid |=> !out_valid)
    else $error("valid longer than one cycle");
  a_out_hold: assert property (
    !out_valid |-> $stable(out_i) && $stable(out_q))
    else $error("output moved without valid");
endmodule // iqa_chk
bind iqa_top iqa_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .parallel_word_clock_o(parallel_word_clock_o),
  .parallel_word_clock_oe(parallel_word_clock_oe),
  .out_i(out_i), .out_q(out_q), .out_valid(out_valid));
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import iqa_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [13:0] data_in;
  logic gate, strobe_drv, ps0, ps1, lock, clk_o, oe, out_valid;
  iqa_sample_t out_i, out_q;
  wire logic pin;
  int err_count, checked;
  // Shared pin: the device drives it unless in single-tone mode
  assign pin = oe ? clk_o : strobe_drv;
  iqa_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_in(data_in), .transmit_gate(gate),
    .parallel_word_clock_o(clk_o), .parallel_word_clock_oe(oe),
    .tuning_update_strobe_i(pin), .profile_select_0(ps0), .profile_select_1(ps1),
    .pll_lock(lock), .out_i(out_i), .out_q(out_q), .out_valid(out_valid));
  iqa_src src (.word_clk(pin), .presetn(presetn), .data_out(data_in), .gate_out(gate));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****
  // Tasks
  // ****
  task automatic conclude;
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout;
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    conclude;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) timeout;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Counts word clock rises, or valid cycles, over w clock intervals
  task automatic count(input int w, input bit pick_valid, output int n);
    logic p, s;
    n = 0;
    @(posedge pclk);
    p = clk_o;
    repeat (w) begin
      @(posedge pclk);
      s = pick_valid ? out_valid : clk_o;
      if (s === 1'b1 && (pick_valid || p === 1'b0)) n++;
      p = s;
    end
  endtask
  task automatic wait_valid(input int n);
    int c;
    c = 0;
    for (int i = 0; i < 4000 && c < n; i++) begin
      @(posedge pclk);
      if (out_valid === 1'b1) c++;
    end
    if (c < n) timeout;
  endtask
  task automatic drain;
    for (int i = 0; i < 400 && src.words.size() > 0; i++) @(posedge pclk);
    if (src.words.size() > 0) timeout;
  endtask
  // Steady response to a level that is a multiple of 256, so scaling is exact
  function automatic int model(input int x, input logic byp, input logic [6:0] cic);
    if (byp || cic[6]) return x;
    return x * (cic[5:0] == 6'h02 ? 242 : 233) / 256;
  endfunction
  task automatic stream(input logic [13:0] a, input logic [13:0] b);
    int i;
    repeat (12) src.push_pair(a, b);
    // Zero pairs keep flowing while the gate is low, so count only after it rises
    for (i = 0; i < 64 && gate !== 1'b1; i++) @(posedge pclk);
    if (gate !== 1'b1) timeout;
    wait_valid(40);
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    logic [31:0] frequency_tuning_word[4];
    logic [31:0] f;
    logic [6:0] cic_tab[4];
    logic byp_tab[4];
    int xi, xq, n, j;
    logic [13:0] a, b;
    cic_tab = '{7'h02, 7'h02, 7'h05, 7'h45};
    byp_tab = '{1'b1, 1'b0, 1'b0, 1'b0};
    {presetn, psel, penable, pwrite, strobe_drv, ps0, ps1} = 7'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    lock = 1'b1;
    err_count = 0;
    checked = 0;
    void'($urandom(72097));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(32'h00, 32'h0, 1'b0);
    rdc(32'h18, 32'h0, 1'b0);
    rdc(32'h1c, 32'h2, 1'b0);
    rdc(32'h04, 32'h0, 1'b1);
    rdc(32'h41, 32'h0, 1'b1);
    rdc(32'h40, 32'h0, 1'b1);
    wr(32'h1c, 32'h1);
    rdc(32'h1c, 32'h2, 1'b0);
    wr(32'h1c, 32'h3f);
    rdc(32'h1c, 32'h3f, 1'b0);
    for (int k = 0; k < 4; k++) begin
      frequency_tuning_word[k] = $urandom;
      wr(32'h20 + 32'(4 * k), frequency_tuning_word[k]);
    end
    for (int k = 1; k < 5; k++) begin
      j = k % 4;
      ps0 <= j[0];
      ps1 <= j[1];
      cyc(8);
      rdc(32'h34, frequency_tuning_word[j], 1'b0);
    end
    wr(32'h00, 32'h1);
    cyc(8);
    check({31'h0, oe}, 32'h0);
    f = $urandom;
    wr(32'h20, f);
    rdc(32'h34, frequency_tuning_word[0], 1'b0);
    strobe_drv <= 1'b1;
    cyc(4);
    strobe_drv <= 1'b0;
    cyc(8);
    rdc(32'h34, f, 1'b0);
    wr(32'h00, 32'h0);
    cyc(8);
    check({31'h0, oe}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(32'h18, {31'h0, byp_tab[k]});
      wr(32'h1c, {25'h0, cic_tab[k]});
      xi = (int'($urandom_range(63)) - 32) * 256;
      xq = (int'($urandom_range(63)) - 32) * 256;
      a = xi[13:0];
      b = xq[13:0];
      stream(a, b);
      check(32'(out_i), 32'(model(xi, byp_tab[k], cic_tab[k])));
      check(32'(out_q), 32'(model(xq, byp_tab[k], cic_tab[k])));
      drain;
      wait_valid(48);
      check(32'(out_i), 32'h0);
      check(32'(out_q), 32'h0);
      count(64, 1'b1, n);
      check(32'(n), 32'h10);
    end
    wr(32'h18, 32'h1);
    wr(32'h00, 32'h2);
    stream(a, a);
    check(32'(out_i), 32'(xi));
    check(32'(out_q), 32'h0);
    count(64, 1'b1, n);
    check(32'(n), 32'h20);
    drain;
    wr(32'h00, 32'h4);
    count(40, 1'b0, n);
    check(32'(n), 32'h5);
    // Drop lock mid high phase, so gating lands inside the low phase
    for (int i = 0; i < 20 && clk_o !== 1'b0; i++) @(posedge pclk);
    for (int i = 0; i < 20 && clk_o !== 1'b1; i++) @(posedge pclk);
    cyc(1);
    lock <= 1'b0;
    cyc(16);
    count(40, 1'b0, n);
    check(32'(n), 32'h0);
    lock <= 1'b1;
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rdc(32'h00, 32'h0, 1'b0);
    conclude;
  end
endmodule // testbench
`default_nettype wire
